// *** rtl/adc_cmd_device.sv ***
// converter end: command decoder and configuration register bank
//
// Design decision made here: the plain strobed port.
`include "adc_cmd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_cmd_device #(
	parameter logic [7:0] DEVICE_ID = 8'h5a, // arbitrary value
	parameter logic [12:0] TMO_LONG = `ADC_TIMEOUT_LONG,
	parameter logic [12:0] TMO_SHORT = `ADC_TIMEOUT_SHORT
) (
	input wire logic clk_sys, // master clock
	input wire logic reset_n, // async reset, active low
	spi_link_if.dev link, // serial link
	input wire logic [7:0] conv_status, // status byte of last result
	input wire logic [15:0] conv_data, // last conversion result
	input wire logic [4:0] monitor_channel, // channel being measured
	input wire logic clock_source_pin, // high: clock pin is input
	input wire logic [7:0] port_pins_in, // port pin levels
	output logic scan_or_fixed_select, // 1 = fixed channel
	output logic external_adc_input_select, // route via ext pins
	output logic clock_out_enable, // drive clock pin
	output logic chop_enable, // external loop chopping
	output logic idle_kind_select, // 1 = sleep
	output logic [2:0] switch_delay, // channel switch delay
	output logic [1:0] bias_current_select, // bias source code
	output logic [1:0] conversion_rate_select, // data rate code
	output logic [7:0] fixed_input_pair, // zero in scan mode
	output logic [31:0] scan_select, // zero in fixed mode
	output logic [7:0] port_direction, // 1 = input
	output logic [7:0] port_value, // output levels
	output logic pulse_convert, // one-cycle convert pulse
	output logic channel_pointer_reset, // one-cycle pulse
	output logic serial_reset // one-cycle pulse on idle-clock interface reset
);
	logic [11:0] sync_s;
	logic sclk_s, cs_n_s, mosi_s, clk_src_s, sclk_d_q;
	logic [7:0] pins_s;
	logic [7:0] regs_q [0:8];
	adc_cmd_pkg::dev_state_t state_q;
	adc_cmd_pkg::op_t op_q;
	adc_cmd_pkg::cmd_code_t code;
	logic [2:0] bit_q;
	logic [7:0] rx_q, tx_q, rx_byte, next_byte, preload;
	logic [3:0] addr_q;
	logic burst_q;
	logic [1:0] dix_q, first_ix;
	logic [12:0] idle_q, limit;
	logic rise, fall, byte_done, tmo, if_reset, reg_we, cmd_reset;

	pin_sync #(.W(12)) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin_in({link.sclk, link.cs_n, link.mosi, clock_source_pin,
			port_pins_in}),
		.pin_out(sync_s)
	);
	assign {sclk_s, cs_n_s, mosi_s, clk_src_s, pins_s} = sync_s;

	// ==========================================================
	// helpers
	function automatic logic [7:0] reg_default(input logic [3:0] a);
		case (a)
			`ADC_REG_MAIN: reg_default = `ADC_DEF_MAIN;
			`ADC_REG_TIMING: reg_default = `ADC_DEF_TIMING;
			`ADC_REG_FIXED: reg_default = `ADC_DEF_FIXED;
			`ADC_REG_SCAN_DIF: reg_default = `ADC_DEF_SCAN_DIF;
			`ADC_REG_SCAN_LO: reg_default = `ADC_DEF_SCAN_LO;
			`ADC_REG_SCAN_HI: reg_default = `ADC_DEF_SCAN_HI;
			`ADC_REG_MONITOR: reg_default = `ADC_DEF_MONITOR;
			`ADC_REG_PORT_DIR: reg_default = `ADC_DEF_PORT_DIR;
			default: reg_default = `ADC_DEF_PORT_VAL;
		endcase
	endfunction

	// reserved bits always read back as zero
	function automatic logic [7:0] reg_mask(input logic [3:0] a);
		case (a)
			`ADC_REG_MAIN: reg_mask = `ADC_MASK_MAIN;
			`ADC_REG_MONITOR: reg_mask = `ADC_MASK_MONITOR;
			default: reg_mask = `ADC_MASK_ALL;
		endcase
	endfunction

	// byte 0 status, 1 data msb, 2 data lsb
	function automatic logic [7:0] data_byte(input logic [1:0] i);
		case (i)
			2'h0: data_byte = conv_status;
			2'h1: data_byte = conv_data[15:8];
			default: data_byte = conv_data[7:0];
		endcase
	endfunction

	// ==========================================================
	// edges, received byte, interface reset causes
	assign rise = sclk_s & ~sclk_d_q;
	assign fall = ~sclk_s & sclk_d_q;
	assign rx_byte = {rx_q[6:0], mosi_s};
	assign byte_done = rise & (bit_q == 3'h7) & ~cs_n_s;
	assign code = adc_cmd_pkg::cmd_code_t'(rx_byte[`ADC_CMD_CODE_HI:
		`ADC_CMD_CODE_LO]);
	assign limit = regs_q[`ADC_REG_MAIN][`ADC_MAIN_TIMEOUT_BIT] ?
		TMO_SHORT : TMO_LONG;
	assign tmo = ~cs_n_s & ~rise & ~fall & (idle_q == limit - 13'h1);
	assign if_reset = cs_n_s | tmo;
	// status leads a direct read only in scan mode with status on
	assign first_ix = (~regs_q[`ADC_REG_MAIN][`ADC_MAIN_FIXED_BIT] &
		regs_q[`ADC_REG_MAIN][`ADC_MAIN_STATUS_BIT]) ? 2'h0 : 2'h1;
	assign preload = data_byte(first_ix);
	assign reg_we = byte_done & (state_q == adc_cmd_pkg::DEV_XFER) &
		(op_q == adc_cmd_pkg::OP_REG_WR);
	assign cmd_reset = byte_done & (state_q == adc_cmd_pkg::DEV_CMD) &
		(code == adc_cmd_pkg::CMD_RESET);

	// byte loaded at each byte boundary of the outgoing stream
	always_comb begin
		next_byte = 8'h00;
		case (state_q)
			adc_cmd_pkg::DEV_CMD: next_byte = preload;
			adc_cmd_pkg::DEV_XFER: begin
				case (op_q)
					adc_cmd_pkg::OP_REG_RD: begin
						if (addr_q == `ADC_REG_PORT_VAL)
							next_byte = pins_s;
						else if (addr_q == `ADC_REG_ID)
							next_byte = DEVICE_ID;
						else if (addr_q < `ADC_REG_ID)
							next_byte = regs_q[addr_q];
						else
							next_byte = 8'h00;
					end
					adc_cmd_pkg::OP_REG_WR: next_byte = 8'h00;
					default: next_byte = data_byte(dix_q);
				endcase
			end
			default: next_byte = 8'h00;
		endcase
	end

	// ==========================================================
	// idle watchdog on the serial clock
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			idle_q <= 13'h0;
			sclk_d_q <= 1'b0;
		end else begin
			sclk_d_q <= sclk_s;
			if (cs_n_s | rise | fall | tmo)
				idle_q <= 13'h0;
			else
				idle_q <= idle_q + 13'h1;
		end
	end

	// shift registers; miso changes on falling edges and on interface reset
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_q <= 8'h00;
			tx_q <= 8'h00;
			bit_q <= 3'h0;
		end else if (if_reset) begin
			bit_q <= 3'h0;
			tx_q <= preload;
		end else begin
			if (rise) begin
				rx_q <= rx_byte;
				bit_q <= bit_q + 3'h1;
			end
			if (fall)
				tx_q <= (bit_q == 3'h0) ? next_byte : {tx_q[6:0], 1'b0};
		end
	end

	// ==========================================================
	// command decoder
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= adc_cmd_pkg::DEV_CMD;
			op_q <= adc_cmd_pkg::OP_REG_RD;
			addr_q <= 4'h0;
			burst_q <= 1'b0;
			dix_q <= 2'h0;
		end else if (if_reset) begin
			state_q <= adc_cmd_pkg::DEV_CMD;
		end else if (byte_done) begin
			case (state_q)
				adc_cmd_pkg::DEV_CMD: begin
					case (code)
						adc_cmd_pkg::CMD_DIRECT_A,
						adc_cmd_pkg::CMD_DIRECT_B: begin
							op_q <= adc_cmd_pkg::OP_DATA_DIRECT;
							dix_q <= first_ix + 2'h1;
							state_q <= adc_cmd_pkg::DEV_XFER;
						end
						adc_cmd_pkg::CMD_DATA_READ: begin
							op_q <= adc_cmd_pkg::OP_DATA_CMD;
							dix_q <= 2'h0;
							state_q <= adc_cmd_pkg::DEV_XFER;
						end
						adc_cmd_pkg::CMD_REG_READ,
						adc_cmd_pkg::CMD_REG_WRITE: begin
							op_q <= (code == adc_cmd_pkg::CMD_REG_READ) ?
								adc_cmd_pkg::OP_REG_RD :
								adc_cmd_pkg::OP_REG_WR;
							addr_q <= rx_byte[`ADC_CMD_ADDR_HI:
								`ADC_CMD_ADDR_LO];
							burst_q <= rx_byte[`ADC_CMD_BURST_BIT];
							state_q <= adc_cmd_pkg::DEV_XFER;
						end
						// pulse, reset and reserved stay ready for a command
						default: state_q <= adc_cmd_pkg::DEV_CMD;
					endcase
				end
				adc_cmd_pkg::DEV_XFER: begin
					if (op_q == adc_cmd_pkg::OP_DATA_CMD ||
						op_q == adc_cmd_pkg::OP_DATA_DIRECT) begin
						if (dix_q == 2'h2)
							state_q <= (op_q == adc_cmd_pkg::OP_DATA_DIRECT) ?
								adc_cmd_pkg::DEV_HOLD :
								adc_cmd_pkg::DEV_CMD;
						else
							dix_q <= dix_q + 2'h1;
					end else if (burst_q && addr_q < `ADC_REG_ID) begin
						addr_q <= addr_q + 4'h1;
					end else begin
						state_q <= adc_cmd_pkg::DEV_CMD;
					end
				end
				// after a direct read only deselect or timeout frees it
				default: state_q <= adc_cmd_pkg::DEV_HOLD;
			endcase
		end
	end

	// ==========================================================
	// register bank; identity and port levels are not stored
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 9; i++)
				regs_q[i] <= reg_default(4'(i));
		end else if (cmd_reset) begin
			for (int i = 0; i < 9; i++)
				regs_q[i] <= reg_default(4'(i));
		end else if (reg_we && addr_q < `ADC_REG_ID) begin
			regs_q[addr_q] <= rx_byte & reg_mask(addr_q);
		end
	end

	// ==========================================================
	// registered side outputs and pulses
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			external_adc_input_select <= 1'b0;
			clock_out_enable <= 1'b0;
			fixed_input_pair <= 8'h00;
			scan_select <= 32'h0;
			pulse_convert <= 1'b0;
			channel_pointer_reset <= 1'b0;
			serial_reset <= 1'b0;
			link.miso_oe <= 1'b0;
		end else begin
			// monitors other than offset always use the internal path
			external_adc_input_select <=
				regs_q[`ADC_REG_MAIN][`ADC_MAIN_EXT_IN_BIT] &
				~(monitor_channel >= `ADC_CH_SUPPLY &&
				monitor_channel <= `ADC_CH_REF);
			clock_out_enable <= regs_q[`ADC_REG_MAIN][`ADC_MAIN_CLK_OUT_BIT] &
				~clk_src_s;
			if (regs_q[`ADC_REG_MAIN][`ADC_MAIN_FIXED_BIT]) begin
				fixed_input_pair <= regs_q[`ADC_REG_FIXED];
				scan_select <= 32'h0;
			end else begin
				fixed_input_pair <= 8'h00;
				scan_select <= {regs_q[`ADC_REG_MONITOR],
					regs_q[`ADC_REG_SCAN_HI], regs_q[`ADC_REG_SCAN_LO],
					regs_q[`ADC_REG_SCAN_DIF]};
			end
			pulse_convert <= byte_done & (state_q == adc_cmd_pkg::DEV_CMD) &
				~if_reset & (code == adc_cmd_pkg::CMD_PULSE);
			channel_pointer_reset <= reg_we &
				addr_q >= `ADC_REG_SCAN_DIF && addr_q <= `ADC_REG_MONITOR;
			serial_reset <= if_reset & ~cs_n_s | tmo;
			link.miso_oe <= ~cs_n_s;
		end
	end

	assign link.miso = tx_q[7];
	assign scan_or_fixed_select = regs_q[`ADC_REG_MAIN][`ADC_MAIN_FIXED_BIT];
	assign chop_enable = regs_q[`ADC_REG_MAIN][`ADC_MAIN_CHOP_BIT];
	assign idle_kind_select = regs_q[`ADC_REG_TIMING][`ADC_TIM_IDLE_BIT];
	assign switch_delay = regs_q[`ADC_REG_TIMING][`ADC_TIM_DELAY_HI:
		`ADC_TIM_DELAY_LO];
	assign bias_current_select = regs_q[`ADC_REG_TIMING][`ADC_TIM_BIAS_HI:
		`ADC_TIM_BIAS_LO];
	assign conversion_rate_select = regs_q[`ADC_REG_TIMING][`ADC_TIM_RATE_HI:
		`ADC_TIM_RATE_LO];
	assign port_direction = regs_q[`ADC_REG_PORT_DIR];
	assign port_value = regs_q[`ADC_REG_PORT_VAL];
endmodule
`default_nettype wire

// *** rtl/adc_cmd_map.svh ***
// register map, field positions, reset values and counts of the command port
`ifndef ADC_CMD_MAP_SVH
`define ADC_CMD_MAP_SVH
// ==========================================================
// register offsets
`define ADC_REG_MAIN 4'h0
`define ADC_REG_TIMING 4'h1
`define ADC_REG_FIXED 4'h2
`define ADC_REG_SCAN_DIF 4'h3
`define ADC_REG_SCAN_LO 4'h4
`define ADC_REG_SCAN_HI 4'h5
`define ADC_REG_MONITOR 4'h6
`define ADC_REG_PORT_DIR 4'h7
`define ADC_REG_PORT_VAL 4'h8
`define ADC_REG_ID 4'h9
// ==========================================================
// reset values and writable-bit masks
`define ADC_DEF_MAIN 8'h0a
`define ADC_DEF_TIMING 8'h83
`define ADC_DEF_FIXED 8'h00
`define ADC_DEF_SCAN_DIF 8'h00
`define ADC_DEF_SCAN_LO 8'hff
`define ADC_DEF_SCAN_HI 8'hff
`define ADC_DEF_MONITOR 8'h00
`define ADC_DEF_PORT_DIR 8'hff
`define ADC_DEF_PORT_VAL 8'h00
`define ADC_MASK_MAIN 8'h7e
`define ADC_MASK_MONITOR 8'h3d
`define ADC_MASK_ALL 8'hff
// ==========================================================
// field positions
`define ADC_MAIN_TIMEOUT_BIT 6
`define ADC_MAIN_FIXED_BIT 5
`define ADC_MAIN_EXT_IN_BIT 4
`define ADC_MAIN_CLK_OUT_BIT 3
`define ADC_MAIN_CHOP_BIT 2
`define ADC_MAIN_STATUS_BIT 1
`define ADC_TIM_IDLE_BIT 7
`define ADC_TIM_DELAY_HI 6
`define ADC_TIM_DELAY_LO 4
`define ADC_TIM_BIAS_HI 3
`define ADC_TIM_BIAS_LO 2
`define ADC_TIM_RATE_HI 1
`define ADC_TIM_RATE_LO 0
`define ADC_CMD_CODE_HI 7
`define ADC_CMD_CODE_LO 5
`define ADC_CMD_BURST_BIT 4
`define ADC_CMD_ADDR_HI 3
`define ADC_CMD_ADDR_LO 0
// ==========================================================
// counts and channel ids
`define ADC_TIMEOUT_LONG 13'd4096
`define ADC_TIMEOUT_SHORT 13'd256
`define ADC_CH_SUPPLY 5'h1a
`define ADC_CH_REF 5'h1d
// ==========================================================
// host controller registers
`define HOST_REG_TX 4'h0
`define HOST_REG_RX 4'h1
`define HOST_REG_STAT 4'h2
`define HOST_TX_END_BIT 8
`define HOST_STAT_BUSY_BIT 0
`define HOST_STAT_OPEN_BIT 1
`define HOST_HALF_CYCLES 8'd6
`endif

// *** rtl/adc_cmd_pkg.sv ***
// types shared by both ends of the command port
package adc_cmd_pkg;
	typedef enum logic [2:0] {
		CMD_DIRECT_A = 3'h0,
		CMD_DATA_READ = 3'h1,
		CMD_REG_READ = 3'h2,
		CMD_REG_WRITE = 3'h3,
		CMD_PULSE = 3'h4,
		CMD_RESERVED = 3'h5,
		CMD_RESET = 3'h6,
		CMD_DIRECT_B = 3'h7
	} cmd_code_t;
	typedef enum logic [1:0] {
		DEV_CMD = 2'h0,
		DEV_XFER = 2'h1,
		DEV_HOLD = 2'h3
	} dev_state_t;
	typedef enum logic [1:0] {
		OP_REG_RD = 2'h0,
		OP_REG_WR = 2'h1,
		OP_DATA_CMD = 2'h3,
		OP_DATA_DIRECT = 2'h2
	} op_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_LOW = 2'h1,
		H_HIGH = 2'h3,
		H_END = 2'h2
	} host_state_t;
endpackage

// *** rtl/spi_link_if.sv ***
// serial link between host controller and converter command port
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	modport dev (input sclk, input cs_n, input mosi, output miso,
		output miso_oe);
	modport host (output sclk, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// *** rtl/pin_sync.sv ***
// two-flop synchroniser for pins from another clock domain
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic [W-1:0] pin_in, // raw pins
	output logic [W-1:0] pin_out // synchronised pins
);
	logic [W-1:0] meta_q;

	// ==========================================================
	// first stage feeds only the second
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			pin_out <= '0;
		end else begin
			meta_q <= pin_in;
			pin_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** rtl/adc_cmd_host.sv ***
// host end: byte-wide serial master driven through a small register port
`include "adc_cmd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_cmd_host #(
	parameter logic [7:0] HALF_CYCLES = `HOST_HALF_CYCLES
) (
	input wire logic clk_sys, // system clock
	input wire logic reset_n, // async reset, active low
	spi_link_if.host link, // serial link
	input wire logic [3:0] reg_addr, // register address
	input wire logic [15:0] reg_wdata, // write data
	input wire logic reg_write, // write strobe
	input wire logic reg_read, // read strobe
	output logic [15:0] reg_rdata // read data, cycle after strobe
);
	adc_cmd_pkg::host_state_t state_q;
	logic [7:0] div_q, tx_q, rx_q;
	logic [2:0] bit_q;
	logic end_q, miso_s, half_done, start;

	pin_sync #(.W(1)) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin_in(link.miso),
		.pin_out(miso_s)
	);

	assign half_done = (div_q == HALF_CYCLES - 8'h1);
	// writes while a byte is in flight are dropped
	assign start = reg_write & (reg_addr == `HOST_REG_TX) &
		(state_q == adc_cmd_pkg::H_IDLE);

	// ==========================================================
	// serial engine: mode 0, sample at end of high phase
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= adc_cmd_pkg::H_IDLE;
			div_q <= 8'h0;
			tx_q <= 8'h0;
			rx_q <= 8'h0;
			bit_q <= 3'h0;
			end_q <= 1'b0;
			link.sclk <= 1'b0;
			link.cs_n <= 1'b1;
			link.mosi <= 1'b0;
		end else begin
			div_q <= half_done ? 8'h0 : div_q + 8'h1;
			case (state_q)
				adc_cmd_pkg::H_IDLE: begin
					div_q <= 8'h0;
					if (start) begin
						tx_q <= reg_wdata[7:0];
						end_q <= reg_wdata[`HOST_TX_END_BIT];
						link.cs_n <= 1'b0;
						link.mosi <= reg_wdata[7];
						bit_q <= 3'h0;
						state_q <= adc_cmd_pkg::H_LOW;
					end
				end
				adc_cmd_pkg::H_LOW: begin
					if (half_done) begin
						link.sclk <= 1'b1;
						state_q <= adc_cmd_pkg::H_HIGH;
					end
				end
				adc_cmd_pkg::H_HIGH: begin
					if (half_done) begin
						link.sclk <= 1'b0;
						rx_q <= {rx_q[6:0], miso_s};
						tx_q <= {tx_q[6:0], 1'b0};
						link.mosi <= tx_q[6];
						bit_q <= bit_q + 3'h1;
						if (bit_q != 3'h7)
							state_q <= adc_cmd_pkg::H_LOW;
						else if (end_q)
							state_q <= adc_cmd_pkg::H_END;
						else
							state_q <= adc_cmd_pkg::H_IDLE;
					end
				end
				// deselect, then hold high for a half period so the
				// device sees the toggle a direct read needs
				default: begin
					if (half_done) begin
						if (link.cs_n)
							state_q <= adc_cmd_pkg::H_IDLE;
						link.cs_n <= 1'b1;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// register read port, data valid for one cycle only
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0;
		end else if (reg_read) begin
			case (reg_addr)
				`HOST_REG_RX: reg_rdata <= {8'h00, rx_q};
				`HOST_REG_STAT: reg_rdata <= {14'h0, ~link.cs_n,
					state_q != adc_cmd_pkg::H_IDLE};
				default: reg_rdata <= 16'h0;
			endcase
		end else begin
			reg_rdata <= 16'h0;
		end
	end
endmodule
`default_nettype wire

// *** verification/adc_cmd_asserts.sv ***
// protocol checker on the serial link between host and converter
`timescale 1ns/100ps
`default_nettype none
module adc_cmd_asserts (
	input wire logic clk_sys, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic sclk, // serial clock
	input wire logic cs_n, // select, active low
	input wire logic mosi, // host to device
	input wire logic miso, // device to host
	input wire logic miso_oe // device drives miso
);
	// ==========================================================
	// link framing and bit timing
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// six-clock half periods give the 3-clock edge lag room
	chk_high_half_len: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
		else $error("sclk high phase not six clocks");
	chk_low_half_len: assert property ($fell(sclk) && !cs_n |-> !sclk [*6])
		else $error("sclk low phase shorter than six clocks");
	chk_select_setup: assert property ($fell(cs_n) |-> !sclk [*6])
		else $error("sclk rose too soon after select");
	chk_idle_clock_low: assert property (cs_n |-> !sclk)
		else $error("sclk active while deselected");
	// data only moves in the low phase, away from the sampling edge
	chk_mosi_held: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi moved while sclk high");
	chk_miso_held: assert property (!cs_n && sclk && $past(sclk) |-> $stable(miso))
		else $error("miso moved while sclk high");
	// enable follows select through the synchroniser
	chk_oe_on_select: assert property (!cs_n [*4] |-> miso_oe)
		else $error("miso not driven while selected");
	chk_oe_off_release: assert property (cs_n [*4] |-> !miso_oe)
		else $error("miso driven while deselected");
endmodule
`default_nettype wire

// *** verification/adc_command_register_interface_tb.sv ***
// self-checking bench: host and converter ends joined by the serial link
`include "adc_cmd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_command_register_interface_tb;
	// ==========================================================
	// harness
	localparam logic [12:0] TL = 13'd128; // shortened idle limits
	localparam logic [12:0] TS = 13'd32;
	localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary value
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [15:0] reg_rdata, q0;
	logic [7:0] conv_status = 8'h9c;
	logic [15:0] conv_data = 16'hbeef;
	logic [4:0] monitor_channel = 5'h00;
	logic clock_source_pin = 1'b0;
	logic [7:0] port_pins_in = 8'ha5;
	logic scan_or_fixed_select, external_adc_input_select, clock_out_enable;
	logic chop_enable, idle_kind_select, pulse_convert, channel_pointer_reset;
	logic serial_reset;
	logic [2:0] switch_delay;
	logic [1:0] bias_current_select, conversion_rate_select;
	logic [7:0] fixed_input_pair, port_direction, port_value, r;
	logic [31:0] scan_select;
	int n_mismatch = 0, compares = 0, cyc = 0, n_pc = 0, n_cp = 0, n_sr = 0;
	int i, n, s;
	spi_link_if link();
	adc_cmd_host adc_cmd_host_inst (.clk_sys, .reset_n, .link(link),
		.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
	adc_cmd_device #(.DEVICE_ID(ID_VAL), .TMO_LONG(TL), .TMO_SHORT(TS))
		adc_cmd_device_inst (.clk_sys, .reset_n, .link(link), .conv_status,
		.conv_data, .monitor_channel, .clock_source_pin, .port_pins_in,
		.scan_or_fixed_select, .external_adc_input_select, .clock_out_enable,
		.chop_enable, .idle_kind_select, .switch_delay, .bias_current_select,
		.conversion_rate_select, .fixed_input_pair, .scan_select,
		.port_direction, .port_value, .pulse_convert, .channel_pointer_reset,
		.serial_reset);
	adc_cmd_asserts adc_cmd_asserts_inst (.clk_sys, .reset_n,
		.sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
		.miso(link.miso), .miso_oe(link.miso_oe));

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	// pulse tallies and the hang limit, well above the ~7.4k cycles needed
	always @(posedge clk_sys) begin
		cyc++;
		if (pulse_convert === 1'b1) n_pc++;
		if (channel_pointer_reset === 1'b1) n_cp++;
		if (serial_reset === 1'b1) n_sr++;
		if (cyc == 30000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (n_mismatch == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [39:0] e,
		input logic [39:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one register-port cycle; read data sampled mid-cycle after the strobe
	task automatic bus(input logic [3:0] a, input logic [15:0] d,
		input logic w, output logic [15:0] q);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= w;
		reg_read <= !w;
		@(posedge clk_sys);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
		@(negedge clk_sys);
		q = reg_rdata;
		@(posedge clk_sys);
	endtask

	// one byte on the link; bit 8 releases select afterwards
	task automatic xfer(input logic [8:0] b, output logic [7:0] rx);
		logic [15:0] q;
		int k;
		bus(`HOST_REG_TX, {7'h00, b}, 1'b1, q);
		q = 16'h0001;
		k = 0;
		while (q[`HOST_STAT_BUSY_BIT] !== 1'b0 && k < 200) begin
			bus(`HOST_REG_STAT, 16'h0000, 1'b0, q);
			k++;
		end
		bus(`HOST_REG_RX, 16'h0000, 1'b0, q);
		rx = q[7:0];
	endtask

	// byte sequence; replies from index k onward are judged
	task automatic seq(input logic [8:0] b [$], input logic [7:0] e [$],
		input int k);
		foreach (b[j]) begin
			xfer(b[j], r);
			if (j >= k)
				chk("reply byte", {32'h0, e[j]}, {32'h0, r});
		end
	endtask

	// waits for the idle-clock interface reset and times it
	task automatic idle(input int t);
		s = n_sr;
		n = 0;
		while (n_sr == s && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		chk("idle reset cycles", 1, {39'h0, n >= t - 16 && n <= t + 8});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_defaults();
		bus(4'hf, 16'h0000, 1'b0, q0);
		chk("unmapped host read", 0, {24'h0, q0});
		seq('{9'h050, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 9'h041, 9'h100},
			'{0, 8'h0a, 8'h83, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff,
			8'ha5, ID_VAL, 8'h9c, 8'h83}, 1);
	endtask

	task automatic t_burst_write();
		s = n_cp;
		seq('{9'h072, 9'h011, 9'h022, 9'h033, 9'h044, 9'h0ff, 9'h066,
			9'h077, 9'h088}, '{0, 0, 0, 0, 0, 0, 0, 0, 0}, 9);
		seq('{9'h056, 0, 0, 0, 9'h100}, '{0, 8'h3d, 8'h66, 8'ha5, ID_VAL},
			1);
		chk("pointer resets", 4, n_cp - s);
		chk("scan selects", {8'h0, 32'h3d443322}, {fixed_input_pair,
			scan_select});
		chk("port regs", 16'h6677, {port_direction, port_value});
	endtask

	task automatic t_config();
		seq('{9'h060, 9'h0bd, 9'h061, 9'h15d}, '{0, 0, 0, 0}, 4);
		repeat (8) @(posedge clk_sys);
		chk("mode fields", 12'hf5d, {scan_or_fixed_select,
			external_adc_input_select, clock_out_enable, chop_enable,
			idle_kind_select, switch_delay, bias_current_select,
			conversion_rate_select});
		chk("fixed selects", 40'h1100000000, {fixed_input_pair,
			scan_select});
		// chopping goes off before any monitor reading is taken
		seq('{9'h060, 9'h0b9, 9'h040, 9'h100}, '{0, 0, 0, 8'h38},
			3);
		clock_source_pin <= 1'b1;
		monitor_channel <= 5'h1b;
		repeat (8) @(posedge clk_sys);
		chk("clock and input", 0, {external_adc_input_select,
			clock_out_enable});
		seq('{9'h000, 9'h100}, '{8'hbe, 8'hef}, 0);
		seq('{9'h030, 0, 0, 9'h100}, '{0, 8'h9c, 8'hbe, 8'hef}, 1);
	endtask

	task automatic t_control();
		s = n_pc;
		seq('{9'h0bf, 9'h09f, 9'h041, 9'h100}, '{0, 0, 0, 8'h5d},
			3);
		chk("convert pulses", 1, n_pc - s);
		seq('{9'h0df, 9'h040, 9'h100}, '{0, 0, 8'h0a}, 2);
		chk("scan after reset", 32'h00ffff00, scan_select);
	endtask

	task automatic t_data_reads();
		seq('{0, 0, 0, 9'h041, 9'h100}, '{8'h9c, 8'hbe, 8'hef, 0, 0},
			0);
		seq('{9'h030, 0, 0, 9'h100}, '{0, 8'h9c, 8'hbe, 8'hef},
			1);
	endtask

	task automatic t_abort_and_timeout();
		s = n_sr;
		seq('{9'h073, 9'h1aa, 9'h043, 9'h100}, '{0, 0, 0, 8'haa}, 3);
		chk("no reset pulse", 0, n_sr - s);
		seq('{9'h053, 0}, '{0, 8'haa}, 1);
		idle(TL);
		seq('{9'h041, 0, 9'h060, 9'h04a}, '{0, 8'h83, 8'h9c, 0},
			1);
		idle(TS);
		seq('{9'h040, 9'h100}, '{0, 8'h4a}, 1);
	endtask

	// reset, then the scenarios in order; each builds on the last
	initial begin
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_defaults();
		t_burst_write();
		t_config();
		t_control();
		t_data_reads();
		t_abort_and_timeout();
		stop_test();
	end
endmodule
`default_nettype wire
